// >>> design/dcpa_consts.svh
`ifndef DCPA_CONSTS_SVH
`define DCPA_CONSTS_SVH

// ==========================================================
// Channel map
`define DCPA_NCH 32
`define DCPA_CH_W 5
`define DCPA_SW_CH 5'd30
`define DCPA_RSV_CH 5'd31

// ==========================================================
// Counts
`define DCPA_CNT_W 11
`define DCPA_NM1_W 10
`define DCPA_ARB_LOG_MAX 4'ha
`define DCPA_ONE 11'h001

// ==========================================================
// Item size and address increment codes
`define DCPA_SIZE_BYTE 2'h0
`define DCPA_SIZE_HALF 2'h1
`define DCPA_SIZE_WORD 2'h2
`define DCPA_INC_NONE 2'h3

// ==========================================================
// Control word mode codes
`define DCPA_MODE_STOP 3'h0
`define DCPA_MODE_BASIC 3'h1
`define DCPA_MODE_AUTO 3'h2
`define DCPA_MODE_PING 3'h3
`define DCPA_MODE_SG 3'h4

`endif

// >>> design/dcpa_pkg.sv
`include "dcpa_consts.svh"

package dcpa_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_MOVE,
    ST_WB
  } dcpa_state_t;

  typedef struct packed {
    logic [`DCPA_CH_W-1:0] chan;
    logic [31:0] src;
    logic [31:0] dst;
    logic [1:0] size;
  } dcpa_item_t;

endpackage

// >>> design/dcpa_prio_pick.sv
`timescale 1ns/10ps
`default_nettype none

module dcpa_prio_pick #(
  parameter int N = 32,
  parameter int IW = 5
) (
  input wire logic [N-1:0] req, // Candidate channels
  output logic found, // Any candidate present
  output logic [IW-1:0] idx // Lowest numbered candidate
);

  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = IW'(i);
      end
    end
  end

endmodule

`default_nettype wire

// >>> design/dcpa_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none

module dcpa_skid_buf #(
  parameter int W = 8
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Receiver takes word
  output logic [W-1:0] out_data // Word out
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } dcpa_buf_t;

  dcpa_buf_t s_r;
  dcpa_buf_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = (s_r.cnt != 2'h2);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = ~s_r.wp;
    end
    if (pop) begin
      s_nxt.rp = ~s_r.rp;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 2'h1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> design/dcpa_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcpa_consts.svh"

module dcpa_arbiter #(
  parameter int NCH = `DCPA_NCH
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [NCH-1:0] pri_single_req, // Primary single requests
  input wire logic [NCH-1:0] pri_burst_req, // Primary burst requests
  input wire logic [NCH-1:0] alt_single_req, // Alternate single requests
  input wire logic [NCH-1:0] alt_burst_req, // Alternate burst requests
  input wire logic [NCH-1:0] sw_req, // Software request pulses
  input wire logic [NCH-1:0] channel_alt_select, // 1 = alternate peripheral
  input wire logic [NCH-1:0] channel_high_prio_set, // Set high priority
  input wire logic [NCH-1:0] channel_high_prio_clear, // Clear high priority
  input wire logic [NCH-1:0] channel_burst_only_set, // Set burst only
  input wire logic [NCH-1:0] channel_burst_only_clear, // Clear burst only
  input wire logic [NCH-1:0] channel_enable_set, // Enable channel
  input wire logic [NCH-1:0] channel_enable_clear, // Disable channel
  output logic [NCH-1:0] high_prio_state, // High priority bits
  output logic [NCH-1:0] burst_only_state, // Burst only bits
  output logic [NCH-1:0] enable_state, // Channel enables
  output logic cfg_req, // Control structure fetch request
  output logic [`DCPA_CH_W-1:0] cfg_chan, // Channel to fetch
  output logic cfg_alt, // 1 = alternate structure
  input wire logic cfg_valid, // Fetched fields valid
  input wire logic [31:0] cfg_src_end, // Source end pointer
  input wire logic [31:0] cfg_dst_end, // Destination end pointer
  input wire logic [1:0] cfg_src_inc, // Source step code
  input wire logic [1:0] cfg_dst_inc, // Destination step code
  input wire logic [1:0] cfg_size, // Item size code
  input wire logic [3:0] cfg_arb_log, // Log2 of arbitration size
  input wire logic [`DCPA_NM1_W-1:0] cfg_n_m1, // Items remaining minus one
  input wire logic [2:0] cfg_mode, // Transfer mode
  output logic wb_valid, // Control word write back
  input wire logic wb_ready, // Write back accepted
  output logic [`DCPA_CH_W-1:0] wb_chan, // Write back channel
  output logic wb_alt, // Write back structure
  output logic [`DCPA_NM1_W-1:0] wb_n_m1, // New remaining minus one
  output logic [2:0] wb_mode, // New mode
  output logic item_valid, // Item move on system bus
  input wire logic item_ready, // Bus takes item
  input wire logic cpu_bus_req, // Processor wants the bus
  output logic [`DCPA_CH_W-1:0] item_chan, // Item channel
  output logic [31:0] item_src, // Item source address
  output logic [31:0] item_dst, // Item destination address
  output logic [1:0] item_size, // Item size code
  output logic grant_active, // A channel holds the grant
  output logic [`DCPA_CH_W-1:0] grant_chan, // Granted channel
  output logic [NCH-1:0] done_irq // Per-channel completion pulse
);

  typedef struct packed {
    logic [NCH-1:0] hi_prio;
    logic [NCH-1:0] burst_only;
    logic [NCH-1:0] enable;
    logic [NCH-1:0] sw_pend;
    logic [NCH-1:0] auto_run;
    logic [NCH-1:0] use_alt;
    logic [NCH-1:0] done;
    dcpa_pkg::dcpa_state_t state;
    logic [`DCPA_CH_W-1:0] chan;
    logic one_item;
    logic [31:0] src_end;
    logic [31:0] dst_end;
    logic [1:0] src_inc;
    logic [1:0] dst_inc;
    logic [1:0] size;
    logic [2:0] mode;
    logic [`DCPA_CNT_W-1:0] left;
    logic [`DCPA_CNT_W-1:0] burst_left;
  } dcpa_arb_t;

  dcpa_arb_t s_r;
  dcpa_arb_t s_nxt;

  logic [NCH-1:0] burst_rq;
  logic [NCH-1:0] single_rq;
  logic [NCH-1:0] elig;
  logic hi_found;
  logic lo_found;
  logic [`DCPA_CH_W-1:0] hi_idx;
  logic [`DCPA_CH_W-1:0] lo_idx;
  logic push_ready;
  logic push_valid;
  logic buf_valid;
  logic bus_take;
  dcpa_pkg::dcpa_item_t push_item;
  dcpa_pkg::dcpa_item_t buf_item;

  // ==========================================================
  // Request qualification
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      burst_rq[i] = channel_alt_select[i] ? alt_burst_req[i]
                                          : pri_burst_req[i];
      single_rq[i] = channel_alt_select[i] ? alt_single_req[i]
                                           : pri_single_req[i];
      if (i >= int'(`DCPA_SW_CH)) begin
        // Software-only and reserved channels see no peripheral
        burst_rq[i] = 1'b0;
        single_rq[i] = 1'b0;
      end
      single_rq[i] = (single_rq[i] & ~s_r.burst_only[i])
                     | s_r.sw_pend[i] | s_r.auto_run[i];
    end
    elig = s_r.enable & (burst_rq | single_rq);
  end

  // ==========================================================
  // Two-level fixed priority
  dcpa_prio_pick #(.N(NCH), .IW(`DCPA_CH_W)) u_pick_hi (
    .req(elig & s_r.hi_prio),
    .found(hi_found),
    .idx(hi_idx)
  );

  dcpa_prio_pick #(.N(NCH), .IW(`DCPA_CH_W)) u_pick_lo (
    .req(elig),
    .found(lo_found),
    .idx(lo_idx)
  );

  // ==========================================================
  // Item address generation
  function automatic logic [31:0] item_addr(
    input logic [31:0] end_ptr,
    input logic [1:0] inc,
    input logic [`DCPA_CNT_W-1:0] left
  );
    logic [31:0] back;
    back = 32'((left - `DCPA_ONE)) << inc;
    if (inc == `DCPA_INC_NONE) begin
      item_addr = end_ptr;
    end else begin
      item_addr = end_ptr - back;
    end
  endfunction

  assign push_valid = (s_r.state == dcpa_pkg::ST_MOVE);
  assign push_item.chan = s_r.chan;
  assign push_item.src = item_addr(s_r.src_end, s_r.src_inc, s_r.left);
  assign push_item.dst = item_addr(s_r.dst_end, s_r.dst_inc, s_r.left);
  assign push_item.size = s_r.size;

  // ==========================================================
  // Engine
  always_comb begin
    logic [3:0] alog;
    logic [`DCPA_CNT_W-1:0] arb;
    logic [`DCPA_CNT_W-1:0] n;
    logic fin;
    alog = '0;
    arb = '0;
    n = '0;
    fin = 1'b0;
    s_nxt = s_r;
    s_nxt.done = '0;
    // Hardware set beats a same-cycle clear
    s_nxt.hi_prio = (s_r.hi_prio & ~channel_high_prio_clear)
                    | channel_high_prio_set;
    s_nxt.burst_only = (s_r.burst_only & ~channel_burst_only_clear)
                       | channel_burst_only_set;
    s_nxt.enable = (s_r.enable & ~channel_enable_clear)
                   | channel_enable_set;
    s_nxt.sw_pend = s_r.sw_pend;
    case (s_r.state)
      dcpa_pkg::ST_IDLE: begin
        // Only place a new grant is made, so bursts run unbroken
        if (hi_found || lo_found) begin
          s_nxt.chan = hi_found ? hi_idx : lo_idx;
          s_nxt.one_item = ~burst_rq[s_nxt.chan];
          s_nxt.state = dcpa_pkg::ST_FETCH;
        end
      end
      dcpa_pkg::ST_FETCH: begin
        if (cfg_valid) begin
          alog = (cfg_arb_log > `DCPA_ARB_LOG_MAX) ? `DCPA_ARB_LOG_MAX
                                                    : cfg_arb_log;
          arb = `DCPA_ONE << alog;
          n = `DCPA_CNT_W'(cfg_n_m1) + `DCPA_ONE;
          s_nxt.src_end = cfg_src_end;
          s_nxt.dst_end = cfg_dst_end;
          s_nxt.src_inc = cfg_src_inc;
          s_nxt.dst_inc = cfg_dst_inc;
          s_nxt.size = cfg_size;
          s_nxt.mode = cfg_mode;
          s_nxt.left = n;
          s_nxt.sw_pend[s_r.chan] = 1'b0;
          if (cfg_mode == `DCPA_MODE_AUTO) begin
            // Auto keeps requesting until the count runs out
            s_nxt.auto_run[s_r.chan] = 1'b1;
          end
          if (s_r.one_item && cfg_mode != `DCPA_MODE_AUTO) begin
            s_nxt.burst_left = `DCPA_ONE;
          end else begin
            s_nxt.burst_left = (arb < n) ? arb : n;
          end
          if (cfg_mode == `DCPA_MODE_STOP) begin
            s_nxt.enable[s_r.chan] = channel_enable_set[s_r.chan];
            s_nxt.auto_run[s_r.chan] = 1'b0;
            s_nxt.state = dcpa_pkg::ST_IDLE;
          end else begin
            s_nxt.state = dcpa_pkg::ST_MOVE;
          end
        end
      end
      dcpa_pkg::ST_MOVE: begin
        // Buffer back-pressure holds the engine here
        if (push_ready) begin
          s_nxt.left = s_r.left - `DCPA_ONE;
          s_nxt.burst_left = s_r.burst_left - `DCPA_ONE;
          if (s_r.burst_left == `DCPA_ONE || s_r.left == `DCPA_ONE) begin
            s_nxt.state = dcpa_pkg::ST_WB;
          end
        end
      end
      default: begin
        if (wb_ready) begin
          fin = (s_r.left == '0);
          if (fin) begin
            s_nxt.done[s_r.chan] = 1'b1;
            s_nxt.auto_run[s_r.chan] = 1'b0;
            if (s_r.mode == `DCPA_MODE_PING ||
                s_r.mode == `DCPA_MODE_SG) begin
              // Continuous modes swap to the other structure
              s_nxt.use_alt[s_r.chan] = ~s_r.use_alt[s_r.chan];
            end else begin
              s_nxt.enable[s_r.chan] = channel_enable_set[s_r.chan];
            end
          end
          s_nxt.state = dcpa_pkg::ST_IDLE;
        end
      end
    endcase
    s_nxt.sw_pend = s_nxt.sw_pend | sw_req;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.state <= dcpa_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Item buffer toward the system bus
  dcpa_skid_buf #(.W($bits(dcpa_pkg::dcpa_item_t))) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_item),
    .out_valid(buf_valid),
    .out_ready(bus_take),
    .out_data(buf_item)
  );

  // Processor always wins the bus
  assign bus_take = item_ready & ~cpu_bus_req;
  assign item_valid = buf_valid & ~cpu_bus_req;
  assign item_chan = buf_item.chan;
  assign item_src = buf_item.src;
  assign item_dst = buf_item.dst;
  assign item_size = buf_item.size;

  // ==========================================================
  // Outputs
  assign high_prio_state = s_r.hi_prio;
  assign burst_only_state = s_r.burst_only;
  assign enable_state = s_r.enable;
  assign cfg_req = (s_r.state == dcpa_pkg::ST_FETCH);
  assign cfg_chan = s_r.chan;
  assign cfg_alt = s_r.use_alt[s_r.chan];
  assign wb_valid = (s_r.state == dcpa_pkg::ST_WB);
  assign wb_chan = s_r.chan;
  assign wb_alt = s_r.use_alt[s_r.chan];
  assign wb_n_m1 = (s_r.left == '0) ? '0
                                    : `DCPA_NM1_W'(s_r.left - `DCPA_ONE);
  assign wb_mode = (s_r.left == '0) ? `DCPA_MODE_STOP : s_r.mode;
  assign grant_active = (s_r.state != dcpa_pkg::ST_IDLE);
  assign grant_chan = s_r.chan;
  assign done_irq = s_r.done;

endmodule

`default_nettype wire

// >>> test/dcpa_arbiter_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcpa_consts.svh"

module dcpa_arbiter_asserts #(
  parameter int NCH = 32
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [NCH-1:0] channel_high_prio_set, // Set strobe
  input wire logic [NCH-1:0] channel_high_prio_clear, // Clear strobe
  input wire logic [NCH-1:0] high_prio_state, // Prio bits
  input wire logic grant_active, // Grant held
  input wire logic [`DCPA_CH_W-1:0] grant_chan, // Winner
  input wire logic cfg_req, // Fetch
  input wire logic [`DCPA_CH_W-1:0] cfg_chan, // Fetch channel
  input wire logic wb_valid, // Write back
  input wire logic wb_ready, // Write back taken
  input wire logic [`DCPA_CH_W-1:0] wb_chan, // Write back channel
  input wire logic [2:0] wb_mode, // New mode
  input wire logic item_valid, // Item
  input wire logic item_ready, // Item taken
  input wire logic cpu_bus_req, // Processor bus
  input wire logic [NCH-1:0] done_irq // Completion
);
  // =====
  // Steps
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence grant_start;
    $rose(grant_active);
  endsequence
  sequence wb_last;
    wb_valid && wb_ready && wb_mode == `DCPA_MODE_STOP;
  endsequence
  // =====
  // Checks
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n |=> !grant_active && !cfg_req && !wb_valid && !item_valid &&
    done_irq == '0 && high_prio_state == '0)
    else $error("state not clear after reset");
  prio_set_a: assert property (1'b1 |=>
    (high_prio_state & $past(channel_high_prio_set)) ==
    $past(channel_high_prio_set))
    else $error("priority bit not set");
  prio_clear_a: assert property (1'b1 |=>
    (high_prio_state & $past(channel_high_prio_clear &
    ~channel_high_prio_set)) == '0)
    else $error("priority bit not cleared");
  grant_hold_a: assert property (
    grant_active && $past(grant_active) |-> $stable(grant_chan))
    else $error("grant moved mid burst");
  grant_fetch_a: assert property (
    grant_start |-> cfg_req && cfg_chan == grant_chan)
    else $error("grant without fetch");
  cpu_yield_a: assert property (cpu_bus_req |-> !item_valid)
    else $error("item offered while processor holds bus");
  item_keep_a: assert property (
    item_valid && !item_ready ##1 !cpu_bus_req |-> item_valid)
    else $error("stalled item lost");
  done_pulse_a: assert property (
    wb_last |=> done_irq == (NCH'(1) << $past(wb_chan)))
    else $error("wrong completion pulse");
  done_cause_a: assert property (
    done_irq != '0 |-> $past(wb_valid && wb_ready))
    else $error("completion without write back");
endmodule

bind dcpa_arbiter dcpa_arbiter_asserts #(.NCH(NCH)) i_asserts (
  .clk, .rst_n, .channel_high_prio_set, .channel_high_prio_clear,
  .high_prio_state, .grant_active, .grant_chan, .cfg_req, .cfg_chan,
  .wb_valid, .wb_ready, .wb_chan, .wb_mode, .item_valid, .item_ready,
  .cpu_bus_req, .done_irq
);
`default_nettype wire

// >>> test/dcpa_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module dcpa_mem_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic slow, // Stall mode
  input wire logic cfg_req, // Fetch request
  output logic cfg_valid, // Fields valid
  output logic [31:0] cfg_src_end, // Source end
  output logic [31:0] cfg_dst_end, // Destination end
  output logic [1:0] cfg_src_inc, // Source step
  output logic [1:0] cfg_dst_inc, // Destination step
  output logic [1:0] cfg_size, // Item size
  output logic [3:0] cfg_arb_log, // Burst log2
  output logic [9:0] cfg_n_m1, // Items left minus one
  output logic [2:0] cfg_mode, // Mode
  output logic wb_ready, // Write back taken
  output logic item_ready // Item taken
);
  // Control structure fields, loaded by the bench
  logic [31:0] src_end, dst_end;
  logic [1:0] src_inc, dst_inc, size;
  logic [3:0] arb_log;
  logic [9:0] n_m1;
  logic [2:0] mode;
  logic [2:0] cyc;
  // Garbage outside the valid cycle so stale fields are never trusted
  assign cfg_src_end = cfg_valid ? src_end : ~src_end;
  assign cfg_dst_end = cfg_valid ? dst_end : ~dst_end;
  assign cfg_src_inc = cfg_valid ? src_inc : ~src_inc;
  assign cfg_dst_inc = cfg_valid ? dst_inc : ~dst_inc;
  assign cfg_size = cfg_valid ? size : ~size;
  assign cfg_arb_log = cfg_valid ? arb_log : ~arb_log;
  assign cfg_n_m1 = cfg_valid ? n_m1 : ~n_m1;
  assign cfg_mode = cfg_valid ? mode : ~mode;
  assign item_ready = !slow || cyc[0];
  assign wb_ready = !slow || cyc[1];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc <= 3'h0;
      cfg_valid <= 1'b0;
    end else begin
      cyc <= cyc + 3'h1;
      cfg_valid <= !cfg_valid && cfg_req && (!slow || cyc[1:0] == 2'h3);
    end
  end
endmodule
`default_nettype wire

// >>> test/dcpa_arbiter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcpa_consts.svh"

module dcpa_arbiter_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic [1:0] cpu_cnt = 2'h0;
  logic [31:0] pri_single_req, pri_burst_req, alt_single_req, alt_burst_req;
  logic [31:0] sw_req, channel_alt_select, channel_high_prio_set;
  logic [31:0] channel_high_prio_clear, channel_burst_only_set;
  logic [31:0] channel_burst_only_clear, channel_enable_set;
  logic [31:0] channel_enable_clear, high_prio_state, burst_only_state;
  logic [31:0] enable_state, done_irq, done_acc;
  logic cfg_req, cfg_alt, cfg_valid, wb_valid, wb_ready, wb_alt, got_alt;
  logic item_valid, item_ready, cpu_bus_req, grant_active;
  logic [`DCPA_CH_W-1:0] cfg_chan, wb_chan, item_chan, grant_chan, it_chan;
  logic [31:0] cfg_src_end, cfg_dst_end, item_src, item_dst, it_src, it_dst;
  logic [1:0] cfg_src_inc, cfg_dst_inc, cfg_size, item_size, it_size;
  logic [3:0] cfg_arb_log;
  logic [`DCPA_NM1_W-1:0] cfg_n_m1, wb_n_m1, got_n_m1;
  logic [2:0] cfg_mode, wb_mode, got_mode;
  int n_errors = 0;
  int n_checks = 0;
  int n_items = 0;

  dcpa_arbiter i_dut (
    .clk, .rst_n, .pri_single_req, .pri_burst_req, .alt_single_req,
    .alt_burst_req, .sw_req, .channel_alt_select, .channel_high_prio_set,
    .channel_high_prio_clear, .channel_burst_only_set,
    .channel_burst_only_clear, .channel_enable_set, .channel_enable_clear,
    .high_prio_state, .burst_only_state, .enable_state, .cfg_req, .cfg_chan,
    .cfg_alt, .cfg_valid, .cfg_src_end, .cfg_dst_end, .cfg_src_inc,
    .cfg_dst_inc, .cfg_size, .cfg_arb_log, .cfg_n_m1, .cfg_mode, .wb_valid,
    .wb_ready, .wb_chan, .wb_alt, .wb_n_m1, .wb_mode, .item_valid,
    .item_ready, .cpu_bus_req, .item_chan, .item_src, .item_dst, .item_size,
    .grant_active, .grant_chan, .done_irq
  );
  dcpa_mem_model i_mem (
    .clk, .rst_n, .slow, .cfg_req, .cfg_valid, .cfg_src_end, .cfg_dst_end,
    .cfg_src_inc, .cfg_dst_inc, .cfg_size, .cfg_arb_log, .cfg_n_m1,
    .cfg_mode, .wb_ready, .item_ready
  );

  always #20 clk = ~clk;
  // In slow mode the processor takes one cycle in four; never locks with item_ready
  always @(negedge clk) cpu_cnt <= cpu_cnt + 2'h1;
  assign cpu_bus_req = slow && cpu_cnt == 2'h0;
  always @(posedge clk) begin
    if (item_valid && item_ready) begin
      n_items <= n_items + 1;
      it_src <= item_src;
      it_dst <= item_dst;
      it_size <= item_size;
      it_chan <= item_chan;
    end
    if (wb_valid && wb_ready) begin
      got_alt <= wb_alt;
      got_n_m1 <= wb_n_m1;
      got_mode <= wb_mode;
    end
    done_acc <= done_acc | done_irq;
  end

  // =====
  // Helpers
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic grab(input logic [`DCPA_CH_W-1:0] ch);
    int i;
    for (i = 0; i < 200 && grant_active !== 1'b1; i++) @(negedge clk);
    if (i == 200) begin
      n_errors++;
      complete_run();
    end
    chk(grant_chan, ch);
    n_items = 0;
    done_acc = '0;
  endtask
  // Negative count waits for idle without counting
  task automatic drain(input int n);
    int i;
    for (i = 0; i < 400 && grant_active !== 1'b0; i++) @(negedge clk);
    if (i == 400) begin
      n_errors++;
      complete_run();
    end
    // Write back can beat the last pop in slow mode; let the buffer empty
    repeat (3) @(negedge clk);
    if (n >= 0) chk(n_items, n);
  endtask
  task automatic ena(input logic [31:0] s, input logic [31:0] c);
    channel_enable_set = s;
    channel_enable_clear = c;
    @(negedge clk);
    {channel_enable_set, channel_enable_clear, channel_burst_only_set} = '0;
  endtask
  task automatic prio(input logic [31:0] s, input logic [31:0] c);
    channel_high_prio_set = s;
    channel_high_prio_clear = c;
    @(negedge clk);
    {channel_high_prio_set, channel_high_prio_clear} = '0;
  endtask
  task automatic setcfg(input logic [9:0] n, input logic [3:0] a,
                        input logic [2:0] m);
    i_mem.n_m1 = n;
    i_mem.arb_log = a;
    i_mem.mode = m;
  endtask
  task automatic no_grant();
    repeat (8) @(negedge clk);
    chk(grant_active, 1'b0);
  endtask
  task automatic stop_all();
    {pri_single_req, pri_burst_req, alt_single_req} = '0;
    ena('0, '1);
    drain(-1);
  endtask

  // =====
  // Scenarios
  task automatic t_single();
    setcfg(10'h2, 4'h3, `DCPA_MODE_BASIC);
    ena(32'h20, '0);
    channel_alt_select[5] = 1'b1;
    pri_single_req[5] = 1'b1;
    no_grant();
    channel_alt_select[5] = 1'b0;
    grab(5'd5);
    pri_single_req[5] = 1'b0;
    drain(1);
    chk(it_src, 32'h0f8);
    chk(it_dst, 32'h200);
    chk(it_chan, 32'h5);
    chk(got_n_m1, 32'h1);
    chk(done_acc, '0);
    stop_all();
  endtask
  task automatic t_prio();
    setcfg(10'h3, 4'h1, `DCPA_MODE_BASIC);
    ena(32'h208, '0);
    pri_burst_req[9] = 1'b1;
    grab(5'd9);
    pri_burst_req[3] = 1'b1;
    prio(32'h8, '0);
    drain(2);
    chk(got_n_m1, 32'h1);
    chk(high_prio_state, 32'h8);
    grab(5'd3);
    prio(32'h200, 32'h8);
    drain(2);
    grab(5'd9);
    prio('0, 32'h200);
    drain(2);
    grab(5'd3);
    drain(2);
    stop_all();
  endtask
  task automatic t_burst_only();
    slow = 1'b1;
    setcfg(10'h4, 4'h1, `DCPA_MODE_BASIC);
    channel_burst_only_set = 32'h80;
    ena(32'h80, '0);
    pri_single_req[7] = 1'b1;
    no_grant();
    chk(burst_only_state, 32'h80);
    pri_burst_req[7] = 1'b1;
    grab(5'd7);
    drain(2);
    chk(got_n_m1, 32'h2);
    channel_burst_only_clear = 32'h80;
    stop_all();
    channel_burst_only_clear = '0;
    slow = 1'b0;
  endtask
  task automatic t_soft();
    setcfg(10'h1, 4'h3, `DCPA_MODE_AUTO);
    ena(32'hc000_0000, '0);
    pri_burst_req[31:30] = 2'h3;
    alt_single_req[31:30] = 2'h3;
    no_grant();
    {pri_burst_req, alt_single_req} = '0;
    sw_req[30] = 1'b1;
    @(negedge clk);
    sw_req[30] = 1'b0;
    grab(5'd30);
    drain(2);
    chk(done_acc, 32'h4000_0000);
    chk(got_mode, `DCPA_MODE_STOP);
    chk(enable_state, 32'h8000_0000);
    stop_all();
  endtask
  task automatic t_modes();
    for (int m = 0; m < 5; m++) begin
      setcfg(10'h0, 4'h0, m[2:0]);
      i_mem.size = 2'(m % 3);
      i_mem.src_inc = 2'(m % 3);
      ena(32'h2, '0);
      sw_req[1] = 1'b1;
      @(negedge clk);
      sw_req[1] = 1'b0;
      grab(5'd1);
      drain(m == 0 ? 0 : 1);
      chk(done_acc, m == 0 ? 32'h0 : 32'h2);
      if (m != 0) chk(it_size, 32'(m % 3));
      if (m != 0) chk(it_src, 32'h100);
      chk(enable_state[1], m >= 3);
      chk(cfg_alt, m == 3);
      chk(got_alt, m == 4);
      stop_all();
    end
  endtask
  task automatic t_reset();
    setcfg(10'h7, 4'h3, `DCPA_MODE_AUTO);
    prio(32'h1, '0);
    ena(32'h1, '0);
    sw_req[0] = 1'b1;
    @(negedge clk);
    sw_req[0] = 1'b0;
    grab(5'd0);
    // Reset in the middle of a grant
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(grant_active, 1'b0);
    chk(high_prio_state | enable_state, '0);
    no_grant();
  endtask

  initial begin
    {pri_single_req, pri_burst_req, alt_single_req, alt_burst_req} = '0;
    {sw_req, channel_alt_select, channel_high_prio_set} = '0;
    {channel_high_prio_clear, channel_burst_only_set} = '0;
    {channel_burst_only_clear, channel_enable_set, channel_enable_clear} = '0;
    {i_mem.src_end, i_mem.dst_end} = {32'h100, 32'h200};
    {i_mem.src_inc, i_mem.dst_inc, i_mem.size} = 6'h2e;
    setcfg(10'h0, 4'h0, `DCPA_MODE_STOP);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk(high_prio_state | burst_only_state | enable_state, '0);
    chk(grant_active, 1'b0);
    t_single();
    t_prio();
    t_burst_only();
    t_soft();
    t_modes();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
